// ---- src/otc_trim_ctrl.sv ----
/*
  Oscillator trim control: holds a 10-bit trim value, loads the stored
  calibration after reset and applies the trim to the oscillator on a commit.
  Assumes a single system clock, an asynchronous power-on reset and a
  software master on the plain register port (read data one cycle later).
  Outputs are all registered; the register port never makes the master wait.
  The option input is a static build setting on the same clock as the port.
*/
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module otc_trim_ctrl
  import otc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Build-time option and stored calibration
  input wire logic trim_feature_option,
  input wire logic [9:0] stored_calibration,
  // Register port
  input wire otc_req_t reg_req,
  output logic [7:0] reg_rdata,
  // Oscillator side
  output logic [9:0] osc_trim_q,
  output logic [2:0] osc_section_q,
  output logic commit_pulse_q
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // The load state lasts exactly one cycle after release
  otc_state_t state_q;                 // Power-on sequencing
  logic [9:0] oscillator_trim_value_q; // Software-visible trim
  logic commit_d;                      // Accepted commit this cycle

  // Decode a write to one address
  // Shared by the register writes, the commit decode and the checks
  function automatic logic wr_hit(input otc_req_t r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction

  // ----------------------------------------------------------------
  // Power-on load sequence
  // ----------------------------------------------------------------
  // One cycle after release leaves the load state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      // Reset parks in the load state
      state_q <= OTC_ST_LOAD;
    end else begin
      // Every later edge stays in run
      state_q <= OTC_ST_RUN;
    end
  end

  // ----------------------------------------------------------------
  // Trim value register
  // ----------------------------------------------------------------
  // Calibration captured after release, then software owns it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      oscillator_trim_value_q <= OTC_TRIM_RESET;
    end else if (state_q == OTC_ST_LOAD) begin
      // Load cycle takes the stored calibration
      oscillator_trim_value_q <= stored_calibration;
    end else begin
      // Software writes, either byte order, option ignored here
      if (wr_hit(reg_req, OTC_ADDR_TRIM_LOW)) begin
        oscillator_trim_value_q[7:0] <= reg_req.wdata;
      end
      if (wr_hit(reg_req, OTC_ADDR_TRIM_HIGH)) begin
        oscillator_trim_value_q[9:8] <= reg_req.wdata[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Commit decode
  // ----------------------------------------------------------------
  // Only the start code with the option set commits; other codes dropped
  // Decoded from the live request so the trim moves on the taking edge
  always_comb begin
    commit_d = wr_hit(reg_req, OTC_ADDR_COMMIT) && (reg_req.wdata == OTC_CMD_START)
               && trim_feature_option && (state_q == OTC_ST_RUN);
  end

  // ----------------------------------------------------------------
  // Oscillator trim output
  // ----------------------------------------------------------------
  // Applied trim takes the calibration at power-on and the software value at each commit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      osc_trim_q <= OTC_TRIM_RESET;
      osc_section_q <= OTC_TRIM_RESET[OTC_TRIM_W-1:OTC_SECT_LSB];
      commit_pulse_q <= 1'b0;
    end else begin
      // Pulse marks each accepted commit for one cycle
      commit_pulse_q <= commit_d;
      if (state_q == OTC_ST_LOAD) begin
        // Load cycle mirrors the calibration
        osc_trim_q <= stored_calibration;
        osc_section_q <= stored_calibration[OTC_TRIM_W-1:OTC_SECT_LSB];
      end else if (commit_d) begin
        // Commit copies the software value
        osc_trim_q <= oscillator_trim_value_q;
        osc_section_q <= oscillator_trim_value_q[OTC_TRIM_W-1:OTC_SECT_LSB];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Data valid only in the cycle after the read strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= OTC_RESET_BYTE;
    end else if (reg_req.rd) begin
      // Read strobe returns the addressed byte
      case (reg_req.addr)
        OTC_ADDR_TRIM_LOW: reg_rdata <= oscillator_trim_value_q[7:0];
        OTC_ADDR_TRIM_HIGH: reg_rdata <= {6'h00, oscillator_trim_value_q[9:8]};
        OTC_ADDR_COMMIT: reg_rdata <= OTC_RESET_BYTE;
        default: reg_rdata <= OTC_RESET_BYTE;
      endcase
    end else begin
      // Without a read the port rests at zero
      reg_rdata <= OTC_RESET_BYTE;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Reset disables every check; the load cycle is watched by name
  chk_commit_applies: assert property (@(posedge clk) disable iff (reset)
    commit_d |=> (osc_trim_q == $past(oscillator_trim_value_q)) && commit_pulse_q)
    else $error("commit did not apply trim");
  chk_option_gates: assert property (@(posedge clk) disable iff (reset)
    !trim_feature_option |=> !commit_pulse_q)
    else $error("commit while option off");
  chk_bad_code_ignored: assert property (@(posedge clk) disable iff (reset)
    (reg_req.wr && reg_req.addr == OTC_ADDR_COMMIT && reg_req.wdata != OTC_CMD_START) |=> !commit_pulse_q)
    else $error("reserved code committed");
  chk_cmd_reads_zero: assert property (@(posedge clk) disable iff (reset)
    (reg_req.rd && reg_req.addr == OTC_ADDR_COMMIT) |=> reg_rdata == 8'h00)
    else $error("command register read nonzero");
  chk_high_read: assert property (@(posedge clk) disable iff (reset)
    (reg_req.rd && reg_req.addr == OTC_ADDR_TRIM_HIGH) |=> reg_rdata[7:2] == 6'h00
      && reg_rdata[1:0] == $past(oscillator_trim_value_q[9:8]))
    else $error("high trim read wrong");
  chk_low_write: assert property (@(posedge clk) disable iff (reset)
    (state_q == OTC_ST_RUN && wr_hit(reg_req, OTC_ADDR_TRIM_LOW))
      |=> oscillator_trim_value_q[7:0] == $past(reg_req.wdata))
    else $error("low trim write lost");
  chk_power_load: assert property (@(posedge clk) disable iff (reset)
    state_q == OTC_ST_LOAD |=> oscillator_trim_value_q == $past(stored_calibration)
      && osc_trim_q == $past(stored_calibration))
    else $error("calibration not loaded");
  chk_section_match: assert property (@(posedge clk) disable iff (reset)
    osc_section_q == osc_trim_q[9:7])
    else $error("section does not match trim");
  chk_trim_holds: assert property (@(posedge clk) disable iff (reset)
    (state_q == OTC_ST_RUN && !commit_d) |=> $stable(osc_trim_q))
    else $error("trim changed without commit");

  // Register port, power-on and option checks
  chk_high_write: assert property (@(posedge clk) disable iff (reset)
    (state_q == OTC_ST_RUN && wr_hit(reg_req, OTC_ADDR_TRIM_HIGH))
      |=> oscillator_trim_value_q[9:8] == $past(reg_req.wdata[1:0]))
    else $error("high trim write lost");
  chk_low_read: assert property (@(posedge clk) disable iff (reset)
    (reg_req.rd && reg_req.addr == OTC_ADDR_TRIM_LOW)
      |=> reg_rdata == $past(oscillator_trim_value_q[7:0]))
    else $error("low trim read wrong");
  chk_rdata_idle: assert property (@(posedge clk) disable iff (reset)
    !reg_req.rd |=> reg_rdata == OTC_RESET_BYTE)
    else $error("read data not idle");
  chk_unmapped_zero: assert property (@(posedge clk) disable iff (reset)
    (reg_req.rd && reg_req.addr != OTC_ADDR_TRIM_LOW && reg_req.addr != OTC_ADDR_TRIM_HIGH)
      |=> reg_rdata == OTC_RESET_BYTE)
    else $error("unmapped read nonzero");
  chk_trim_untouched: assert property (@(posedge clk) disable iff (reset)
    (state_q == OTC_ST_RUN && !wr_hit(reg_req, OTC_ADDR_TRIM_LOW) && !wr_hit(reg_req, OTC_ADDR_TRIM_HIGH))
      |=> $stable(oscillator_trim_value_q))
    else $error("trim register changed unwritten");
  chk_load_once: assert property (@(posedge clk) disable iff (reset)
    state_q == OTC_ST_RUN |=> state_q == OTC_ST_RUN)
    else $error("load state entered twice");
  chk_refused_holds: assert property (@(posedge clk) disable iff (reset)
    (state_q == OTC_ST_RUN && !trim_feature_option) |=> $stable(osc_trim_q))
    else $error("trim moved with option off");

  // Commit source check
  chk_pulse_needs_cmd: assert property (@(posedge clk) disable iff (reset)
    commit_pulse_q |-> $past(wr_hit(reg_req, OTC_ADDR_COMMIT) && reg_req.wdata == OTC_CMD_START
      && trim_feature_option))
    else $error("pulse without start code");

  // ----------------------------------------------------------------
  // Coverage of the main scenarios
  // ----------------------------------------------------------------
  cov_commit: cover property (@(posedge clk) disable iff (reset) commit_pulse_q);
  cov_refused: cover property (@(posedge clk) disable iff (reset)
    wr_hit(reg_req, OTC_ADDR_COMMIT) && !trim_feature_option);
  cov_write_commit: cover property (@(posedge clk) disable iff (reset)
    wr_hit(reg_req, OTC_ADDR_TRIM_HIGH) ##[1:4] commit_d);
  cov_bad_code: cover property (@(posedge clk) disable iff (reset)
    wr_hit(reg_req, OTC_ADDR_COMMIT) && reg_req.wdata != OTC_CMD_START);
  cov_power_load: cover property (@(posedge clk) disable iff (reset)
    state_q == OTC_ST_LOAD ##1 state_q == OTC_ST_RUN);

endmodule // otc_trim_ctrl

`default_nettype wire

// ---- src/otc_pkg.sv ----
/*
  Constants and carrier types for the oscillator trim control block.
  Assumes a byte-wide special function register port on the system clock.
*/
package otc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OTC_ADDR_TRIM_LOW = 8'hf2;   // Trim value bits 7..0
  localparam logic [7:0] OTC_ADDR_TRIM_HIGH = 8'hf3;  // Trim value bits 9..8
  localparam logic [7:0] OTC_ADDR_COMMIT = 8'hf4;     // Write-only command

  // ----------------------------------------------------------------
  // Fields, codes and reset values
  // ----------------------------------------------------------------
  localparam int OTC_TRIM_W = 10;                     // Trim value width
  localparam int OTC_SECT_LSB = 7;                    // Section select low bit
  localparam logic [7:0] OTC_CMD_START = 8'h3c;       // Commit start code
  localparam logic [7:0] OTC_RESET_BYTE = 8'h00;      // Register reset value
  localparam logic [9:0] OTC_TRIM_RESET = 10'h000;    // Trim reset value
  localparam logic [9:0] OTC_CAL_DEFAULT = 10'h200;   // Plain default calibration

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Register port request from software
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } otc_req_t;

  // Power-on sequencing states, Gray coded
  typedef enum logic [1:0] {
    OTC_ST_LOAD = 2'b00,
    OTC_ST_RUN = 2'b01
  } otc_state_t;

endpackage

// ---- tb/test_oscillator_trim_control.sv ----
/*
  Self-checking bench for the oscillator trim control block.
  Assumes otc_pkg and otc_trim_ctrl are compiled before this file.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_count++; $display("ERROR %s exp %h got %h", n, e, s); end end

module test_oscillator_trim_control;
  import otc_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus, model and design
  // ----------------------------------------------------------------
  logic clk = 1'b0; // 25 MHz system clock
  logic reset = 1'b1; // Power-on reset
  logic trim_feature_option = 1'b1; // Tuning option
  logic [9:0] stored_calibration; // Calibration input
  otc_req_t reg_req = '0; // Register request
  logic [7:0] reg_rdata; // Read data
  logic [9:0] osc_trim_q; // Applied trim
  logic [2:0] osc_section_q; // Applied section
  logic commit_pulse_q; // Commit pulse
  integer seed = 32'hab04; // Random seed
  integer err_count = 0; // Mismatches
  integer num_checks = 0; // Comparisons
  logic [9:0] trim_m; // Model of the trim register
  logic [9:0] osc_m; // Model of the applied trim
  logic [7:0] rd_v; // Value read back
  logic [7:0] cd; // Random byte
  integer k; // Section index

  otc_trim_ctrl i_otc_trim_ctrl (.clk(clk), .reset(reset), .trim_feature_option(trim_feature_option),
    .stored_calibration(stored_calibration), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .osc_trim_q(osc_trim_q), .osc_section_q(osc_section_q), .commit_pulse_q(commit_pulse_q));

  // Half period toggle
  always #20 clk = ~clk;

  // One-cycle write, returns just after the taking edge
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    reg_req <= '0;
    #1;
  endtask

  // One-cycle read, data taken in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    reg_req <= '0;
    #1 d = reg_rdata;
  endtask

  // Oscillator side against the model
  task automatic chk_osc(input logic p);
    `CHK("osc_trim", osc_m, osc_trim_q)
    `CHK("section", osc_m[9:7], osc_section_q)
    `CHK("commit_pulse", p, commit_pulse_q)
  endtask

  // Counts, verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("ERROR watchdog exp done got hang");
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    stored_calibration <= 10'($random(seed));
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    trim_m = stored_calibration;
    osc_m = stored_calibration;
    repeat (2) @(posedge clk);
    #1;
    chk_osc(1'b0);
    bus_rd(OTC_ADDR_TRIM_LOW, rd_v);
    `CHK("low", trim_m[7:0], rd_v)
    @(posedge clk);
    #1;
    `CHK("rdata_idle", 8'h00, reg_rdata)
    $display("power-on load test done");
    // Software has slowed the CPU divider before this sweep
    for (k = 0; k < 8; k++) begin
      bus_rd(OTC_ADDR_TRIM_HIGH, rd_v);
      `CHK("high_prior", {6'h00, trim_m[9:8]}, rd_v)
      bus_rd(OTC_ADDR_TRIM_LOW, rd_v);
      `CHK("low_prior", trim_m[7:0], rd_v)
      cd = 8'($random(seed));
      trim_m = {k[2:0], cd[6:0]};
      cd = 8'($random(seed));
      bus_wr(OTC_ADDR_TRIM_HIGH, {cd[7:2], trim_m[9:8]});
      bus_wr(OTC_ADDR_TRIM_LOW, trim_m[7:0]);
      bus_rd(OTC_ADDR_TRIM_HIGH, rd_v);
      `CHK("high", {6'h00, trim_m[9:8]}, rd_v)
      bus_rd(OTC_ADDR_TRIM_LOW, rd_v);
      `CHK("low", trim_m[7:0], rd_v)
      cd = 8'($random(seed));
      if (cd == OTC_CMD_START) begin
        cd = 8'h00;
      end
      bus_wr(OTC_ADDR_COMMIT, cd);
      chk_osc(1'b0);
      @(posedge clk);
      trim_feature_option <= 1'b0;
      trim_m[0] = ~trim_m[0];
      bus_wr(OTC_ADDR_TRIM_LOW, trim_m[7:0]);
      bus_wr(OTC_ADDR_COMMIT, OTC_CMD_START);
      chk_osc(1'b0);
      @(posedge clk);
      trim_feature_option <= 1'b1;
      bus_wr(OTC_ADDR_COMMIT, OTC_CMD_START);
      osc_m = trim_m;
      chk_osc(1'b1);
      // Fetch-rate check after retune stays with software
      bus_rd(OTC_ADDR_COMMIT, rd_v);
      `CHK("cmd_read", 8'h00, rd_v)
      bus_rd(8'hf5 + {5'h00, k[2:0]}, rd_v);
      `CHK("unmapped", 8'h00, rd_v)
    end
    $display("section sweep test done");
    report_and_stop();
  end
endmodule // test_oscillator_trim_control
`default_nettype wire
